/* ivpr_responder.v */
// Inquiry page responder: page streamer, command option checks, activation
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "ivpr_defs.vh"

// Overview of operation
// - Extended capability page carries code 86h and length 003Ch in bytes 1-3.
// - Report activation field 01b; switch microcode before final download completes.
// - After activation raise changed-microcode attention on all nexuses but the sender.
// - Report protection type field 001b: types 1 and 2 supported.
// - Report all three tag verify flags set; verify tags whenever protection present.
// - Attention key-specific, grouping and priority flags zero; none of them supported.
// - Head-of-queue, ordered and simple attribute flags set; all three accepted.
// - Both write-long flags set; accept uncorrectable and correction-disable options.
// - Non-volatile cache flag zero, volatile cache flag one.
// - Protection interval and referrals flags zero.
// - Power-on activation flag set; accept deferred activation write buffer mode 0Dh.
// - Byte 13 reports the largest sense length returned with status.
// - Mode page policy page carries code 87h and length 0004h.
// - Policy descriptor gives page code 3Fh and subpage FFh.
// - Shared policy flag set.
// - Mode page policy field reads 00b.
module ivpr_responder (
  input  wire       clk,
  input  wire       reset_n,
  // Register port
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  output wire       irq,
  // Inquiry page request and byte stream
  input  wire       inq_req,
  input  wire [7:0] inq_page,
  output wire       inq_busy,
  output wire       out_valid,
  output reg  [7:0] out_data,
  output wire       out_last,
  input  wire       out_ready,
  output reg        inq_bad_page,
  // Write buffer download and activation
  input  wire       wb_cmd,
  input  wire [7:0] wb_mode,
  input  wire       wb_final,
  input  wire [2:0] wb_nexus,
  input  wire       activate_at_poweron_option,
  input  wire       activate_at_hardreset_option,
  input  wire       activate_vendor_option,
  output reg        wb_accept,
  output reg        wb_reject,
  output reg        code_switch,
  output reg        wb_done,
  output reg        poweron_pending,
  output reg  [7:0] ua_pending,
  input  wire [7:0] ua_clear,
  output wire [7:0] ua_asc,
  output wire [7:0] ua_ascq,
  // Write long and task attribute checks
  input  wire       wl_cmd,
  input  wire       mark_uncorrectable_option,
  input  wire       disable_correction_option,
  output reg        wl_accept,
  input  wire       task_cmd,
  input  wire [1:0] task_attr,
  input  wire       task_group_nz,
  input  wire       task_prio_nz,
  output reg        task_accept,
  output reg        task_reject,
  // Protection information check
  input  wire       pi_check,
  input  wire       pi_present,
  input  wire       guard_mismatch,
  input  wire       app_mismatch,
  input  wire       ref_mismatch,
  output reg        pi_error
);

  // One-hot states of the page streamer
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_SEND = 2'b10;
  // Mask reset value, trimmed to the implemented status bits
  localparam [7:0] MASK_RST = `IVPR_MASK_RST;

  reg  [1:0] state_ff;
  reg  [1:0] nxt_state;
  reg  [5:0] idx_ff;
  reg  [5:0] nxt_idx;
  reg        policy_ff;
  reg        nxt_policy;
  reg  [5:0] last_ff;
  reg  [5:0] nxt_last;
  reg  [7:0] nxt_out_data;
  reg        nxt_bad_page;
  reg  [7:0] ctrl_ff;
  reg  [`IVPR_ST_BITS-1:0] status_ff;
  reg  [`IVPR_ST_BITS-1:0] mask_ff;
  reg  [`IVPR_ST_BITS-1:0] evt;
  reg  [2:0] act_nexus_ff;
  reg  [5:0] rom_idx;
  reg        rom_policy;
  wire [7:0] rom_byte;
  wire       enable;
  wire       beat;
  wire       inq_ext;
  wire       inq_pol;
  wire       wb_ok;
  // Register write decodes and command qualifiers
  wire       wr_ctrl;
  wire       wr_status;
  wire       wr_mask;
  wire       wr_defer;
  wire       wb_act_req;
  wire       attr_known;

  assign enable   = ctrl_ff[0];
  assign inq_busy = state_ff[1];
  assign out_valid = state_ff[1];
  assign beat     = state_ff[1] & out_ready;
  assign out_last = state_ff[1] & (idx_ff == last_ff);
  assign inq_ext  = inq_page == `IVPR_PAGE_EXT_CAP;
  assign inq_pol  = inq_page == `IVPR_PAGE_POLICY;
  // Fixed sense code pair reported with the attention
  assign ua_asc   = `IVPR_UA_ASC;
  assign ua_ascq  = `IVPR_UA_ASCQ;

  // Write strobes decoded once per register
  assign wr_ctrl   = reg_wr & (reg_addr == `IVPR_REG_CTRL);
  assign wr_status = reg_wr & (reg_addr == `IVPR_REG_STATUS);
  assign wr_mask   = reg_wr & (reg_addr == `IVPR_REG_MASK);
  assign wr_defer  = reg_wr & (reg_addr == `IVPR_REG_DEFER);

  // Byte lookup: at a start it shows byte 0 of the new page, else the next byte
  always @* begin
    rom_policy = policy_ff;
    rom_idx    = idx_ff + 6'h01;
    if (state_ff[0]) begin
      rom_policy = inq_pol;
      rom_idx    = 6'h00;
    end
  end

  ivpr_page_rom u_rom (
    .policy_page (rom_policy),
    .byte_idx    (rom_idx),
    .page_byte   (rom_byte)
  );

  // Streamer: a request is taken only when idle and enabled; busy ignores requests
  always @* begin
    nxt_state    = state_ff;
    nxt_idx      = idx_ff;
    nxt_policy   = policy_ff;
    nxt_last     = last_ff;
    nxt_out_data = out_data;
    nxt_bad_page = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (inq_req && enable) begin
          if (inq_ext || inq_pol) begin
            nxt_state    = ST_SEND;
            nxt_idx      = 6'h00;
            nxt_policy   = inq_pol;
            nxt_last     = inq_pol ? `IVPR_LAST_POLICY : `IVPR_LAST_EXT_CAP;
            nxt_out_data = rom_byte;
          end else begin
            nxt_bad_page = 1'b1;
          end
        end
      end
      ST_SEND: begin
        if (beat) begin
          if (idx_ff == last_ff) begin
            nxt_state = ST_IDLE;
          end else begin
            nxt_idx      = idx_ff + 6'h01;
            nxt_out_data = rom_byte;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Streamer registers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff     <= ST_IDLE;
      idx_ff       <= 6'h00;
      policy_ff    <= 1'b0;
      last_ff      <= 6'h00;
      out_data     <= 8'h00;
      inq_bad_page <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      idx_ff       <= nxt_idx;
      policy_ff    <= nxt_policy;
      last_ff      <= nxt_last;
      out_data     <= nxt_out_data;
      inq_bad_page <= nxt_bad_page;
    end
  end

  // Mode 0Dh may only ask for power-on activation; other modes pass through
  assign wb_ok = (wb_mode != `IVPR_WB_MODE_ACTIVATE) ||
                 (!activate_at_hardreset_option && !activate_vendor_option);

  // Attribute code 3 is none of the three supported ones and is refused
  assign attr_known = (task_attr == `IVPR_ATTR_SIMPLE) | (task_attr == `IVPR_ATTR_QHEAD) |
                      (task_attr == `IVPR_ATTR_ORDERED);
  // Accepted mode 0Dh request asking for activation at next power-on
  assign wb_act_req = wb_cmd & wb_ok & (wb_mode == `IVPR_WB_MODE_ACTIVATE) &
                      activate_at_poweron_option;

  // Command option checks, each answered by a one-cycle pulse
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_accept   <= 1'b0;
      wb_reject   <= 1'b0;
      wl_accept   <= 1'b0;
      task_accept <= 1'b0;
      task_reject <= 1'b0;
      pi_error    <= 1'b0;
    end else begin
      wb_accept   <= wb_cmd & wb_ok;
      wb_reject   <= wb_cmd & ~wb_ok;
      // Both write-long options are legal in any combination
      wl_accept   <= wl_cmd;
      task_accept <= task_cmd & ~task_group_nz & ~task_prio_nz & attr_known;
      task_reject <= task_cmd & (task_group_nz | task_prio_nz | ~attr_known);
      // Tags are always checked when protection information travels with the data
      pi_error    <= pi_check & pi_present &
                     (guard_mismatch | app_mismatch | ref_mismatch);
    end
  end

  // Deferred activation flag: armed by an accepted power-on request
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      poweron_pending <= 1'b0;
    end else if (wb_act_req) begin
      poweron_pending <= 1'b1;
    end else if (wr_defer && reg_wdata[0]) begin
      poweron_pending <= 1'b0;
    end
  end

  // Switch first, report completion one cycle later so the new code is live
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      code_switch  <= 1'b0;
      wb_done      <= 1'b0;
      act_nexus_ff <= 3'h0;
    end else begin
      code_switch <= wb_final;
      wb_done     <= code_switch;
      if (wb_final) begin
        act_nexus_ff <= wb_nexus;
      end
    end
  end

  // Attention per nexus; a new activation beats a clear in the same cycle
  genvar g;
  generate
    for (g = 0; g < `IVPR_NEXUS; g = g + 1) begin : g_ua
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          ua_pending[g] <= 1'b0;
        end else if (code_switch && act_nexus_ff != g) begin
          ua_pending[g] <= 1'b1;
        end else if (ua_clear[g]) begin
          ua_pending[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Event sources for the sticky status bits
  always @* begin
    evt = {`IVPR_ST_BITS{1'b0}};
    evt[`IVPR_ST_DONE]       = beat & out_last;
    evt[`IVPR_ST_BADPAGE]    = inq_bad_page;
    evt[`IVPR_ST_ACTIVATE]   = code_switch;
    evt[`IVPR_ST_WBREJECT]   = wb_reject;
    evt[`IVPR_ST_ATTRREJECT] = task_reject;
    evt[`IVPR_ST_PIERROR]    = pi_error;
  end

  // Control and mask registers, plain read-write
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= `IVPR_CTRL_RST;
      mask_ff <= MASK_RST[`IVPR_ST_BITS-1:0];
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= reg_wdata;
      end
      if (wr_mask) begin
        mask_ff <= reg_wdata[`IVPR_ST_BITS-1:0];
      end
    end
  end

  // Write-one-to-clear status; set wins over clear, so an event
  // arriving while software acknowledges another is never lost
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_ff <= {`IVPR_ST_BITS{1'b0}};
    end else if (wr_status) begin
      status_ff <= (status_ff & ~reg_wdata[`IVPR_ST_BITS-1:0]) | evt;
    end else begin
      status_ff <= status_ff | evt;
    end
  end

  // Level interrupt, high while any unmasked status bit stays set
  assign irq = |(status_ff & mask_ff);

  // Read data stand one cycle after the strobe and read zero otherwise
  // Reads have no side effect, so polling status loses no event
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `IVPR_REG_CTRL:   reg_rdata <= ctrl_ff;
        `IVPR_REG_STATUS: reg_rdata <= {2'h0, status_ff};
        `IVPR_REG_MASK:   reg_rdata <= {2'h0, mask_ff};
        `IVPR_REG_UA:     reg_rdata <= ua_pending;
        `IVPR_REG_DEFER:  reg_rdata <= {7'h00, poweron_pending};
        default:          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // ivpr_responder
`default_nettype wire

/* ivpr_defs.vh */
// Constants for the inquiry vital product data page responder
`ifndef IVPR_DEFS_VH
`define IVPR_DEFS_VH

// Page codes and page lengths
`define IVPR_PAGE_EXT_CAP      8'h86
`define IVPR_PAGE_POLICY       8'h87
`define IVPR_LEN_EXT_CAP       16'h003c
`define IVPR_LEN_POLICY        16'h0004
`define IVPR_LAST_EXT_CAP      6'h3f
`define IVPR_LAST_POLICY       6'h07
`define IVPR_PERIPH_BYTE       8'h00

// Extended capability page field values
`define IVPR_ACT_MICROCODE     2'h1
`define IVPR_PROT_TYPE         3'h1
`define IVPR_GUARD_VERIFY      1'h1
`define IVPR_APP_VERIFY        1'h1
`define IVPR_REF_VERIFY        1'h1
`define IVPR_ATTN_KEY_SPEC     1'h0
`define IVPR_GROUP_SUP         1'h0
`define IVPR_PRIOR_SUP         1'h0
`define IVPR_QHEAD_ATTR        1'h1
`define IVPR_ORDERED_ATTR      1'h1
`define IVPR_SIMPLE_ATTR       1'h1
`define IVPR_WR_UNCORR         1'h1
`define IVPR_CORR_DISABLE      1'h1
`define IVPR_NV_CACHE          1'h0
`define IVPR_VOL_CACHE         1'h1
`define IVPR_PI_INTERVAL       1'h0
`define IVPR_LU_CLEAR          1'h0
`define IVPR_REFERRALS         1'h0
`define IVPR_CBCS              1'h0
`define IVPR_MULTI_NEXUS_DL    4'h0
`define IVPR_PON_ACTIVATE      1'h1
`define IVPR_HRST_ACTIVATE     1'h0
`define IVPR_VEND_ACTIVATE     1'h0
`define IVPR_MAX_SENSE_LEN     8'h20
`define IVPR_SELFTEST_MIN      16'h0000

// Mode page policy page field values
`define IVPR_POLICY_PAGE       6'h3f
`define IVPR_POLICY_SUBPAGE    8'hff
`define IVPR_SHARED_POLICY     1'h1
`define IVPR_MODE_POLICY       2'h0

// Command codes checked by the block, and the attention sense code pair
`define IVPR_WB_MODE_ACTIVATE  8'h0d
`define IVPR_ATTR_SIMPLE       2'h0
`define IVPR_ATTR_QHEAD        2'h1
`define IVPR_ATTR_ORDERED      2'h2
`define IVPR_UA_ASC            8'h3f
`define IVPR_UA_ASCQ           8'h01

// Register offsets
`define IVPR_REG_CTRL          4'h0
`define IVPR_REG_STATUS        4'h1
`define IVPR_REG_MASK          4'h2
`define IVPR_REG_UA            4'h3
`define IVPR_REG_DEFER         4'h4
`define IVPR_CTRL_RST          8'h01
`define IVPR_MASK_RST          8'h00

// Status bit positions
`define IVPR_ST_DONE           0
`define IVPR_ST_BADPAGE        1
`define IVPR_ST_ACTIVATE       2
`define IVPR_ST_WBREJECT       3
`define IVPR_ST_ATTRREJECT     4
`define IVPR_ST_PIERROR        5
`define IVPR_ST_BITS           6

`define IVPR_NEXUS             8
`endif

/* ivpr_page_rom.v */
// Byte images of the extended capability and mode page policy pages
`timescale 1ns/10ps
`default_nettype none
`include "ivpr_defs.vh"

module ivpr_page_rom (
  input  wire       policy_page,
  input  wire [5:0] byte_idx,
  output reg  [7:0] page_byte
);

  // Two-byte fields, split into bytes by part-select below
  localparam [15:0] LEN_EXT_CAP = `IVPR_LEN_EXT_CAP;
  localparam [15:0] LEN_POLICY  = `IVPR_LEN_POLICY;
  localparam [15:0] SELFTEST    = `IVPR_SELFTEST_MIN;

  // Unlisted bytes fall to zero, so every reserved byte reads as zero
  always @* begin
    page_byte = 8'h00;
    if (!policy_page) begin
      case (byte_idx)
        6'h00: page_byte = `IVPR_PERIPH_BYTE;
        6'h01: page_byte = `IVPR_PAGE_EXT_CAP;
        6'h02: page_byte = LEN_EXT_CAP[15:8];
        6'h03: page_byte = LEN_EXT_CAP[7:0];
        6'h04: page_byte = {`IVPR_ACT_MICROCODE, `IVPR_PROT_TYPE,
                            `IVPR_GUARD_VERIFY, `IVPR_APP_VERIFY, `IVPR_REF_VERIFY};
        6'h05: page_byte = {2'h0, `IVPR_ATTN_KEY_SPEC, `IVPR_GROUP_SUP, `IVPR_PRIOR_SUP,
                            `IVPR_QHEAD_ATTR, `IVPR_ORDERED_ATTR, `IVPR_SIMPLE_ATTR};
        6'h06: page_byte = {4'h0, `IVPR_WR_UNCORR, `IVPR_CORR_DISABLE,
                            `IVPR_NV_CACHE, `IVPR_VOL_CACHE};
        6'h07: page_byte = {3'h0, `IVPR_PI_INTERVAL, 3'h0, `IVPR_LU_CLEAR};
        6'h08: page_byte = {3'h0, `IVPR_REFERRALS, 3'h0, `IVPR_CBCS};
        6'h09: page_byte = {4'h0, `IVPR_MULTI_NEXUS_DL};
        6'h0a: page_byte = SELFTEST[15:8];
        6'h0b: page_byte = SELFTEST[7:0];
        6'h0c: page_byte = {`IVPR_PON_ACTIVATE, `IVPR_HRST_ACTIVATE,
                            `IVPR_VEND_ACTIVATE, 5'h00};
        6'h0d: page_byte = `IVPR_MAX_SENSE_LEN;
        default: page_byte = 8'h00;
      endcase
    end else begin
      case (byte_idx)
        6'h00: page_byte = `IVPR_PERIPH_BYTE;
        6'h01: page_byte = `IVPR_PAGE_POLICY;
        6'h02: page_byte = LEN_POLICY[15:8];
        6'h03: page_byte = LEN_POLICY[7:0];
        6'h04: page_byte = {2'h0, `IVPR_POLICY_PAGE};
        6'h05: page_byte = `IVPR_POLICY_SUBPAGE;
        6'h06: page_byte = {`IVPR_SHARED_POLICY, 5'h00, `IVPR_MODE_POLICY};
        default: page_byte = 8'h00;
      endcase
    end
  end

endmodule // ivpr_page_rom
`default_nettype wire

/* ivpr_asserts.sv */
// Port checker for the inquiry page responder
`timescale 1ns/10ps
`default_nettype none
module ivpr_asserts (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       inq_req,
  input wire logic [7:0] inq_page,
  input wire logic       inq_busy,
  input wire logic       out_valid,
  input wire logic [7:0] out_data,
  input wire logic       out_last,
  input wire logic       out_ready,
  input wire logic       wb_cmd,
  input wire logic [7:0] wb_mode,
  input wire logic       activate_at_hardreset_option,
  input wire logic       activate_vendor_option,
  input wire logic       wb_reject,
  input wire logic       wb_final,
  input wire logic [2:0] wb_nexus,
  input wire logic       code_switch,
  input wire logic       wb_done,
  input wire logic [7:0] ua_pending,
  input wire logic       task_cmd,
  input wire logic [1:0] task_attr,
  input wire logic       task_group_nz,
  input wire logic       task_prio_nz,
  input wire logic       task_accept
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;
  logic [7:0] pg_ff;
  // Beat index inside the page, so byte checks need no copy of the image
  always_comb nxt_cnt = !(out_valid && out_ready) ? cnt_ff : out_last ? 6'h00 : cnt_ff + 6'h01;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 6'h00;
      pg_ff <= 8'h00;
    end else begin
      cnt_ff <= nxt_cnt;
      pg_ff <= (inq_req && !inq_busy) ? inq_page : pg_ff;
    end
  end
  a_first_byte: assert property (inq_req && !inq_busy && inq_page[7:1] == 7'h43
    |=> out_valid && out_data == 8'h00) else $error("page did not start at byte 0");
  a_page_code: assert property (out_valid && cnt_ff == 6'h01 |-> out_data == pg_ff)
    else $error("page code byte wrong");
  a_page_length: assert property (out_valid && out_last
    |-> cnt_ff == (pg_ff == 8'h86 ? 6'h3f : 6'h07)) else $error("page length wrong");
  a_stall_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("byte changed while stalled");
  a_wb_refuse: assert property (wb_cmd && wb_mode == 8'h0d
    && (activate_at_hardreset_option || activate_vendor_option) |=> wb_reject)
    else $error("activation request not refused");
  a_switch_then_done: assert property (wb_final |=> code_switch ##1 wb_done)
    else $error("microcode switch timing wrong");
  a_ua_others: assert property (wb_final
    |-> ##2 ((ua_pending | (8'h01 << $past(wb_nexus, 2))) == 8'hff))
    else $error("attention missing on a nexus");
  a_task_accept: assert property (task_cmd && task_attr != 2'h3 && !task_group_nz
    && !task_prio_nz |=> task_accept) else $error("task attribute refused");
  c_page_end: cover property (out_valid && out_ready && out_last);
  c_stall: cover property (out_valid && !out_ready);
  c_activate: cover property (wb_final ##2 wb_done);
endmodule // ivpr_asserts
bind ivpr_responder ivpr_asserts i_ivpr_asserts (.clk, .reset_n, .inq_req, .inq_page,
  .inq_busy, .out_valid, .out_data, .out_last, .out_ready, .wb_cmd, .wb_mode,
  .activate_at_hardreset_option, .activate_vendor_option, .wb_reject, .wb_final, .wb_nexus,
  .code_switch, .wb_done, .ua_pending, .task_cmd, .task_attr, .task_group_nz, .task_prio_nz,
  .task_accept);
`default_nettype wire

/* ivpr_initiator.sv */
// Initiator model: takes page bytes, with optional random stalls
`timescale 1ns/10ps
`default_nettype none
module ivpr_initiator (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       start,
  input  wire logic       stall_en,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  input  wire logic       out_last,
  output var  logic       out_ready,
  output var  logic       rx_done,
  output var  logic [6:0] rx_n
);
  logic [7:0]  rx_mem [0:63];
  logic [15:0] lfsr_ff;
  // Random ready drops force the source to hold its byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lfsr_ff <= 16'hace1;
      out_ready <= 1'b0;
    end else begin
      lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
      out_ready <= !stall_en || lfsr_ff[0];
    end
  end
  // Bytes kept in arrival order; a new request clears the record
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_n <= 7'h00;
      rx_done <= 1'b0;
    end else if (start) begin
      rx_n <= 7'h00;
      rx_done <= 1'b0;
    end else if (out_valid && out_ready && !rx_done) begin
      rx_mem[rx_n[5:0]] <= out_data;
      rx_n <= rx_n + 7'h01;
      rx_done <= out_last;
    end
  end
endmodule // ivpr_initiator
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the inquiry page responder
`timescale 1ns/10ps
`default_nettype none
`include "ivpr_defs.vh"
module testbench;
  logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, inq_req = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, inq_page = 8'h00, wb_mode = 8'h00, ua_clear = 8'h00;
  logic [7:0] reg_rdata, out_data, ua_pending, ua_asc, ua_ascq;
  logic irq, inq_busy, out_valid, out_last, out_ready, inq_bad_page, rx_done, ok;
  logic wb_cmd = 1'b0, wb_final = 1'b0, wl_cmd = 1'b0, task_cmd = 1'b0, pi_check = 1'b0;
  logic [2:0] wb_nexus = 3'h0;
  logic [1:0] task_attr = 2'h0;
  logic activate_at_poweron_option = 1'b0, activate_at_hardreset_option = 1'b0;
  logic activate_vendor_option = 1'b0, mark_uncorrectable_option = 1'b0;
  logic disable_correction_option = 1'b0, task_group_nz = 1'b0, task_prio_nz = 1'b0;
  logic pi_present = 1'b0, guard_mismatch = 1'b0, app_mismatch = 1'b0, ref_mismatch = 1'b0;
  logic wb_accept, wb_reject, code_switch, wb_done, poweron_pending, wl_accept;
  logic task_accept, task_reject, pi_error, start = 1'b0, stall_en = 1'b0;
  logic [6:0] rx_n;
  logic [31:0] seed = 32'd17492;
  logic [31:0] r;
  int errors = 0, n_tests = 0, i, k;
  always #4 clk = ~clk;
  ivpr_responder i_ivpr_responder (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq, .inq_req, .inq_page, .inq_busy, .out_valid, .out_data, .out_last,
    .out_ready, .inq_bad_page, .wb_cmd, .wb_mode, .wb_final, .wb_nexus,
    .activate_at_poweron_option, .activate_at_hardreset_option, .activate_vendor_option,
    .wb_accept, .wb_reject, .code_switch, .wb_done, .poweron_pending, .ua_pending, .ua_clear,
    .ua_asc, .ua_ascq, .wl_cmd, .mark_uncorrectable_option, .disable_correction_option,
    .wl_accept, .task_cmd, .task_attr, .task_group_nz, .task_prio_nz, .task_accept,
    .task_reject, .pi_check, .pi_present, .guard_mismatch, .app_mismatch, .ref_mismatch,
    .pi_error);
  ivpr_initiator i_ivpr_initiator (.clk(clk), .reset_n(reset_n), .start(start),
    .stall_en(stall_en), .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
    .out_ready(out_ready), .rx_done(rx_done), .rx_n(rx_n));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected page image, byte by byte
  function automatic logic [7:0] exp_byte(input logic pol, input int n);
    case ({pol, n[5:0]})
      7'h01: return 8'h86;
      7'h03: return 8'h3c;
      7'h04: return 8'h4f;
      7'h05: return 8'h07;
      7'h06: return 8'h0d;
      7'h07: return 8'h00;
      7'h08: return 8'h00;
      7'h0c: return 8'h80;
      7'h0d: return `IVPR_MAX_SENSE_LEN;
      7'h41: return 8'h87;
      7'h43: return 8'h04;
      7'h44: return 8'h3f;
      7'h45: return 8'hff;
      7'h46: return 8'h80;
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string m);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e, m);
  endtask
  task automatic page(input logic [7:0] pg);
    @(posedge clk);
    inq_req <= 1'b1;
    inq_page <= pg;
    start <= 1'b1;
    @(posedge clk);
    inq_req <= 1'b0;
    start <= 1'b0;
    // A second request in mid-stream is ignored
    @(posedge clk);
    inq_req <= 1'b1;
    inq_page <= pg ^ 8'h01;
    @(posedge clk);
    inq_req <= 1'b0;
    #1 chk({inq_busy, out_valid}, 8'h03, "busy");
    for (k = 0; k < 400 && !rx_done; k++) @(posedge clk);
    #1 chk({1'b0, rx_n}, pg[0] ? 8'h08 : 8'h40, "byte count");
    for (k = 0; k < rx_n; k++) chk(i_ivpr_initiator.rx_mem[k], exp_byte(pg[0], k), "byte");
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd(4'h0, 8'h01, "ctrl reset");
    rd(4'h2, 8'h00, "mask reset");
    wr(4'h9, 8'h5a);
    rd(4'h9, 8'h00, "unmapped");
    $display("registers done");
    for (i = 0; i < 4; i++) begin
      stall_en <= i[1];
      page(i[0] ? 8'h87 : 8'h86);
    end
    $display("pages done");
    for (i = 0; i < 16; i++) begin
      r = rnd();
      @(posedge clk);
      wb_cmd <= 1'b1;
      wb_mode <= i[3] ? r[7:0] : `IVPR_WB_MODE_ACTIVATE;
      {activate_at_poweron_option, activate_at_hardreset_option, activate_vendor_option} <= i[2:0];
      @(posedge clk);
      wb_cmd <= 1'b0;
      #1 ok = wb_mode == 8'h0d && i[1:0] != 2'h0;
      chk(wb_reject, ok, "refusal");
      chk(wb_accept, !ok, "accept");
      chk(poweron_pending, !ok && wb_mode == 8'h0d && i[2], "pending pin");
      rd(4'h4, {7'h00, !ok && wb_mode == 8'h0d && i[2]}, "poweron pending");
      wr(4'h4, 8'h01);
    end
    for (i = 0; i < 4; i++) begin
      r = rnd();
      @(posedge clk);
      ua_clear <= 8'hff;
      @(posedge clk);
      ua_clear <= 8'h00;
      wb_final <= 1'b1;
      wb_nexus <= r[2:0];
      @(posedge clk);
      wb_final <= 1'b0;
      #1 chk({code_switch, wb_done}, 8'h02, "switch");
      @(posedge clk);
      #1 chk(wb_done, 1'b1, "done");
      chk(ua_pending, ~(8'h01 << r[2:0]), "attention");
      chk({ua_asc, ua_ascq} == 16'h3f01, 1'b1, "sense code");
    end
    $display("activation done");
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      {task_cmd, wl_cmd, pi_check} <= 3'h7;
      {task_attr, task_group_nz, task_prio_nz} <= i[3:0];
      {mark_uncorrectable_option, disable_correction_option} <= i[1:0];
      {pi_present, guard_mismatch, app_mismatch, ref_mismatch} <= i[3:0];
      @(posedge clk);
      {task_cmd, wl_cmd, pi_check} <= 3'h0;
      #1 ok = i[3:2] != 2'h3 && i[1:0] == 2'h0;
      chk({task_accept, task_reject}, {6'h00, ok, !ok}, "task");
      chk(wl_accept, 1'b1, "write long");
      chk(pi_error, i[3] && i[2:0] != 3'h0, "tag check");
    end
    $display("options done");
    @(posedge clk);
    inq_req <= 1'b1;
    inq_page <= 8'h83;
    @(posedge clk);
    inq_req <= 1'b0;
    #1 chk({inq_bad_page, out_valid}, 8'h02, "bad page");
    rd(4'h1, 8'h3f, "status");
    wr(4'h2, 8'h02);
    chk(irq, 1'b1, "irq raised");
    wr(4'h1, 8'h3f);
    chk(irq, 1'b0, "irq cleared");
    rd(4'h1, 8'h00, "status cleared");
    $display("interrupt done");
    conclude();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    errors++;
    conclude();
  end
endmodule // testbench
`default_nettype wire
